// ==== osc_defs.svh ====
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH
// Register offsets
`define OSC_ADDR_EXP_HI 7'h06
`define OSC_ADDR_EXP_LO 7'h07
`define OSC_ADDR_MAX 7'h08
`define OSC_ADDR_SUM 7'h09
`define OSC_ADDR_MIN 7'h0a
`define OSC_ADDR_GRAB 7'h0b
`define OSC_ADDR_CTRL 7'h0d
`define OSC_ADDR_KEY 7'h3a
`define OSC_ADDR_INVREV 7'h3f
`define OSC_ADDR_BURST 7'h63
// Field positions and values
`define OSC_RESTART_KEY 8'h5a
`define OSC_CTRL_SLEEP_BIT 1
`define OSC_CTRL_CPI_BIT 0
`define OSC_CTRL_RST 2'h0
`define OSC_CTRL_PAD 6'h00
`define OSC_SUM_MSB 14
`define OSC_SUM_LSB 7
`define OSC_SUM_PEAK 15'h6f9f
`define OSC_SUM_BYTE_PEAK 8'hdf
`define OSC_PIX_PEAK 7'h7f
`define OSC_PIX_FIRST 8'h00
`define OSC_PIX_LAST 8'he0
`define OSC_BYTE_ZERO 8'h00
// Exposure control
`define OSC_EXP_RST 16'h0000
`define OSC_EXP_MIN 16'h0001
`define OSC_EXP_MAX 16'hffff
`define OSC_EXP_STEP 16'h0010
`define OSC_MAX_HIGH 7'h78
`define OSC_SUM_HIGH 15'h5800
`define OSC_SUM_LOW 15'h1800
// Displacement saturation
`define OSC_DELTA_POS 8'h7f
`define OSC_DELTA_NEG 8'h80
`endif

// ==== osc_pkg.sv ====
package osc_pkg;
  typedef enum logic [2:0] {
    BS_IDLE = 3'b000,
    BS_DX = 3'b001,
    BS_DY = 3'b010,
    BS_SQ = 3'b011,
    BS_EH = 3'b100,
    BS_EL = 3'b101,
    BS_MAX = 3'b110,
    BS_SUM = 3'b111
  } osc_burst_t;
  typedef logic [6:0] osc_pix_t;
endpackage : osc_pkg

// ==== osc_stat_if.sv ====
`timescale 1ns/1ps
interface osc_stat_if;
  import osc_pkg::*;
  logic pix_valid;
  logic pix_first;
  osc_pix_t pix_data;
  logic [7:0] pix_pos;
  logic frame_done;
  osc_pix_t max_val;
  osc_pix_t min_val;
  logic [14:0] sum_val;
  modport stats (input pix_valid, input pix_first, input pix_data, output pix_pos,
                 output frame_done, output max_val, output min_val, output sum_val);
  modport core (output pix_valid, output pix_first, output pix_data, input pix_pos,
                input frame_done, input max_val, input min_val, input sum_val);
endinterface : osc_stat_if

// ==== osc_frame_stats.sv ====
`timescale 1ns/1ps
`include "osc_defs.svh"
module osc_frame_stats
  import osc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  osc_stat_if.stats sif
);
  logic [7:0] cnt_r;
  osc_pix_t run_max_r;
  osc_pix_t run_min_r;
  logic [14:0] acc_r;
  osc_pix_t max_r;
  osc_pix_t min_r;
  logic [14:0] sum_r;
  logic done_r;
  logic first_w;
  logic [7:0] pos_w;
  osc_pix_t cur_max_w;
  osc_pix_t cur_min_w;
  logic [14:0] cur_acc_w;
  logic last_w;

  ////////////////////////////////////////////////////////////////////////////
  // Running statistics over one frame
  assign first_w = sif.pix_valid && sif.pix_first;
  assign pos_w = first_w ? `OSC_PIX_FIRST : cnt_r;
  assign cur_max_w = (first_w || sif.pix_data > run_max_r) ? sif.pix_data : run_max_r;
  assign cur_min_w = (first_w || sif.pix_data < run_min_r) ? sif.pix_data : run_min_r;
  assign cur_acc_w = 15'((first_w ? 15'h0000 : acc_r) + {8'h00, sif.pix_data});
  assign last_w = sif.pix_valid && pos_w == `OSC_PIX_LAST;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cnt_r <= `OSC_PIX_FIRST;
      run_max_r <= 7'h00;
      run_min_r <= 7'h00;
      acc_r <= 15'h0000;
      max_r <= 7'h00;
      min_r <= 7'h00;
      sum_r <= 15'h0000;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= last_w;
      if (sif.pix_valid)
      begin
        cnt_r <= 8'(pos_w + 8'h01);
        run_max_r <= cur_max_w;
        run_min_r <= cur_min_w;
        acc_r <= cur_acc_w;
      end
      if (last_w)
      begin
        max_r <= cur_max_w;
        min_r <= cur_min_w;
        sum_r <= cur_acc_w;
      end
    end
  end

  assign sif.pix_pos = pos_w;
  assign sif.frame_done = done_r;
  assign sif.max_val = max_r;
  assign sif.min_val = min_r;
  assign sif.sum_val = sum_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_stats_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    done_r |-> max_r <= `OSC_PIX_PEAK && min_r <= max_r)
    else $error("frame extremes out of order or range");
  a_sum_cap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    done_r |-> sum_r <= `OSC_SUM_PEAK && sum_r[`OSC_SUM_MSB:`OSC_SUM_LSB] <= `OSC_SUM_BYTE_PEAK)
    else $error("pixel sum above peak");
endmodule : osc_frame_stats

// ==== osc_sensor_regs.sv ====
`timescale 1ns/1ps
`include "osc_defs.svh"
// Function
// - Exposure is 16-bit count, high 0x06, low 0x07
// - Exposure self-adjusts from mean and peak levels
// - Brightest pixel of frame, 0..127, every frame outside power down
// - Brightness total is sum bits 14..7
// - Darkest pixel at 0x0a, 0..127, every frame outside power down
// - Sampler captures at most one pixel per frame, none until read
// - Sampler read with pixel: flag, value, advance
// - Sampler write resets index, arms pixel zero
// - Settings bit 1 selects power down
// - Settings bit 0 selects 500/1000 cpi
// - Key 0x5a at 0x3a restarts chip
// - 0x3f reads inverted revision code
// - Reading 0x63 starts streaming burst readout
// - Burst order: dx, dy, quality, exposure, max, sum
// - Burst past total repeats brightness total
// - Raising select line ends the burst
// - Displacements signed, accumulated, cleared by reading
// - Quality byte is upper eight of nine bits
module osc_sensor_regs
  import osc_pkg::*;
#(
  // Arbitrary neutral revision code
  parameter logic [7:0] REV_CODE = 8'h2d
)
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic select_low_line_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic pix_valid_i,
  input wire logic pix_first_i,
  input wire logic [6:0] pix_data_i,
  input wire logic motion_valid_i,
  input wire logic [7:0] motion_dx_i,
  input wire logic [7:0] motion_dy_i,
  input wire logic [8:0] squal_i,
  output logic power_down_o,
  output logic counts_per_inch_select_o,
  output logic [15:0] exposure_o,
  output logic chip_restart_o
);
  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7])
      sat_add = s[8] ? `OSC_DELTA_NEG : `OSC_DELTA_POS;
    else
      sat_add = s[7:0];
  endfunction : sat_add

  function automatic logic [15:0] exp_step(input logic [15:0] e, input logic [6:0] mx,
                                           input logic [14:0] sm);
    if (mx > `OSC_MAX_HIGH || sm > `OSC_SUM_HIGH)
      exp_step = (e > 16'(`OSC_EXP_MIN + `OSC_EXP_STEP)) ? 16'(e - `OSC_EXP_STEP)
                                                         : `OSC_EXP_MIN;
    else if (sm < `OSC_SUM_LOW)
      exp_step = (e < 16'(`OSC_EXP_MAX - `OSC_EXP_STEP)) ? 16'(e + `OSC_EXP_STEP)
                                                         : `OSC_EXP_MAX;
    else
      exp_step = e;
  endfunction : exp_step

  osc_stat_if sif ();

  logic soft_rst_r;
  logic rst_w;
  logic [2:0] sel_sync_r;
  logic sel_lvl_r;
  osc_burst_t burst_r;
  osc_burst_t burst_nxt;
  logic [7:0] dx_acc_r;
  logic [7:0] dy_acc_r;
  logic [15:0] exp_r;
  logic [7:0] exp_lo_snap_r;
  logic [1:0] ctrl_r;
  osc_pix_t grab_hold_r;
  logic grab_valid_r;
  logic grab_armed_r;
  logic grab_pend_r;
  logic [7:0] grab_idx_r;
  logic [7:0] rdata_r;
  logic rvalid_r;

  logic burst_on_w;
  logic burst_go_w;
  logic burst_rd_w;
  logic grab_rd_w;
  logic grab_wr_w;
  logic grab_pop_w;
  logic arm_now_w;
  logic cap_w;
  logic exp_hi_rd_w;
  logic exp_lo_rd_w;
  logic dx_clr_w;
  logic dy_clr_w;
  logic key_w;
  logic ctrl_wr_w;
  logic [7:0] sum_byte_w;
  logic [7:0] grab_byte_w;
  logic [7:0] burst_byte_w;
  logic [7:0] addr_byte_w;
  logic [7:0] rd_byte_w;
  logic [7:0] dx_nxt;
  logic [7:0] dy_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Restart and select line
  assign key_w = reg_wr_i && hit(reg_addr_i, `OSC_ADDR_KEY) && reg_wdata_i == `OSC_RESTART_KEY;
  assign rst_w = sys_rst_i | soft_rst_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= key_w;
  end

  // Select line is high when idle; level taken once stages two and three agree
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_w)
    begin
      sel_sync_r <= 3'b111;
      sel_lvl_r <= 1'b1;
    end
    else
    begin
      sel_sync_r <= {sel_sync_r[1:0], select_low_line_i};
      if (sel_sync_r[1] == sel_sync_r[2])
        sel_lvl_r <= sel_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign burst_on_w = burst_r != BS_IDLE;
  assign burst_go_w = reg_rd_i && !burst_on_w && hit(reg_addr_i, `OSC_ADDR_BURST);
  assign burst_rd_w = reg_rd_i && burst_on_w;
  assign grab_rd_w = reg_rd_i && !burst_on_w && hit(reg_addr_i, `OSC_ADDR_GRAB);
  assign grab_wr_w = reg_wr_i && hit(reg_addr_i, `OSC_ADDR_GRAB);
  assign grab_pop_w = grab_rd_w && grab_valid_r && !grab_wr_w;
  assign exp_hi_rd_w = (reg_rd_i && !burst_on_w && hit(reg_addr_i, `OSC_ADDR_EXP_HI)) ||
                       (burst_rd_w && burst_r == BS_EH);
  assign exp_lo_rd_w = (reg_rd_i && !burst_on_w && hit(reg_addr_i, `OSC_ADDR_EXP_LO)) ||
                       (burst_rd_w && burst_r == BS_EL);
  assign dx_clr_w = burst_go_w;
  assign dy_clr_w = burst_rd_w && burst_r == BS_DY;
  assign ctrl_wr_w = reg_wr_i && hit(reg_addr_i, `OSC_ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer
  always_comb
  begin
    burst_nxt = burst_r;
    if (sel_lvl_r)
      burst_nxt = BS_IDLE;
    else if (burst_go_w)
      burst_nxt = BS_DY;
    else if (burst_rd_w)
    begin
      case (burst_r)
        BS_DY: burst_nxt = BS_SQ;
        BS_SQ: burst_nxt = BS_EH;
        BS_EH: burst_nxt = BS_EL;
        BS_EL: burst_nxt = BS_MAX;
        BS_MAX: burst_nxt = BS_SUM;
        BS_SUM: burst_nxt = BS_SUM;
        default: burst_nxt = BS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_w)
      burst_r <= BS_IDLE;
    else
      burst_r <= burst_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Displacement accumulators; new motion outweighs the read clear
  assign dx_nxt = dx_clr_w ? (motion_valid_i ? motion_dx_i : `OSC_BYTE_ZERO) :
                  (motion_valid_i ? sat_add(dx_acc_r, motion_dx_i) : dx_acc_r);
  assign dy_nxt = dy_clr_w ? (motion_valid_i ? motion_dy_i : `OSC_BYTE_ZERO) :
                  (motion_valid_i ? sat_add(dy_acc_r, motion_dy_i) : dy_acc_r);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_w)
    begin
      dx_acc_r <= `OSC_BYTE_ZERO;
      dy_acc_r <= `OSC_BYTE_ZERO;
    end
    else
    begin
      dx_acc_r <= dx_nxt;
      dy_acc_r <= dy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame statistics and exposure loop; power down freezes the pixel stream
  assign sif.pix_valid = pix_valid_i && !ctrl_r[`OSC_CTRL_SLEEP_BIT];
  assign sif.pix_first = pix_first_i;
  assign sif.pix_data = pix_data_i;

  osc_frame_stats u_stats (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_w),
    .sif(sif.stats)
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_w)
    begin
      exp_r <= `OSC_EXP_RST;
      exp_lo_snap_r <= `OSC_BYTE_ZERO;
    end
    else
    begin
      if (sif.frame_done)
        exp_r <= exp_step(exp_r, sif.max_val, sif.sum_val);
      if (exp_hi_rd_w)
        exp_lo_snap_r <= exp_r[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel sampler
  assign arm_now_w = grab_pend_r && sif.pix_valid && sif.pix_first;
  assign cap_w = (grab_armed_r || arm_now_w) && sif.pix_valid && sif.pix_pos == grab_idx_r &&
                 !grab_wr_w && !grab_pop_w;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_w)
    begin
      grab_hold_r <= 7'h00;
      grab_valid_r <= 1'b0;
      grab_armed_r <= 1'b0;
      grab_pend_r <= 1'b1;
      grab_idx_r <= `OSC_PIX_FIRST;
    end
    else if (grab_wr_w)
    begin
      grab_idx_r <= `OSC_PIX_FIRST;
      grab_valid_r <= 1'b0;
      grab_armed_r <= 1'b0;
      grab_pend_r <= 1'b1;
    end
    else if (grab_pop_w)
    begin
      grab_idx_r <= (grab_idx_r == `OSC_PIX_LAST) ? `OSC_PIX_FIRST : 8'(grab_idx_r + 8'h01);
      grab_valid_r <= 1'b0;
      grab_pend_r <= 1'b1;
    end
    else if (cap_w)
    begin
      grab_hold_r <= sif.pix_data;
      grab_valid_r <= 1'b1;
      grab_armed_r <= 1'b0;
      grab_pend_r <= 1'b0;
    end
    else if (arm_now_w)
    begin
      grab_armed_r <= 1'b1;
      grab_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_w)
      ctrl_r <= `OSC_CTRL_RST;
    else if (ctrl_wr_w)
      ctrl_r <= reg_wdata_i[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  assign sum_byte_w = sif.sum_val[`OSC_SUM_MSB:`OSC_SUM_LSB];
  assign grab_byte_w = grab_valid_r ? {1'b1, grab_hold_r} : `OSC_BYTE_ZERO;
  assign burst_byte_w = (burst_r == BS_DY) ? dy_acc_r :
                        (burst_r == BS_SQ) ? squal_i[8:1] :
                        (burst_r == BS_EH) ? exp_r[15:8] :
                        (burst_r == BS_EL) ? exp_lo_snap_r :
                        (burst_r == BS_MAX) ? {1'b0, sif.max_val} :
                        (burst_r == BS_SUM) ? sum_byte_w : `OSC_BYTE_ZERO;
  assign addr_byte_w = hit(reg_addr_i, `OSC_ADDR_EXP_HI) ? exp_r[15:8] :
                       hit(reg_addr_i, `OSC_ADDR_EXP_LO) ? exp_lo_snap_r :
                       hit(reg_addr_i, `OSC_ADDR_MAX) ? {1'b0, sif.max_val} :
                       hit(reg_addr_i, `OSC_ADDR_SUM) ? sum_byte_w :
                       hit(reg_addr_i, `OSC_ADDR_MIN) ? {1'b0, sif.min_val} :
                       hit(reg_addr_i, `OSC_ADDR_GRAB) ? grab_byte_w :
                       hit(reg_addr_i, `OSC_ADDR_CTRL) ? {`OSC_CTRL_PAD, ctrl_r} :
                       hit(reg_addr_i, `OSC_ADDR_INVREV) ? ~REV_CODE :
                       `OSC_BYTE_ZERO;
  assign rd_byte_w = burst_go_w ? dx_acc_r : (burst_on_w ? burst_byte_w : addr_byte_w);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_w)
    begin
      rdata_r <= `OSC_BYTE_ZERO;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i)
        rdata_r <= rd_byte_w;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign power_down_o = ctrl_r[`OSC_CTRL_SLEEP_BIT];
  assign counts_per_inch_select_o = ctrl_r[`OSC_CTRL_CPI_BIT];
  assign exposure_o = exp_r;
  assign chip_restart_o = soft_rst_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_w);

  sequence s_burst_read(osc_burst_t st);
    burst_rd_w && !sel_lvl_r && burst_r == st;
  endsequence

  a_exp_pair: assert property (exp_hi_rd_w && !exp_lo_rd_w |=>
    exp_lo_snap_r == $past(exp_r[7:0]) && reg_rdata_o == $past(exp_r[15:8]))
    else $error("exposure pair not latched together");
  a_exp_loop: assert property (sif.frame_done && sif.sum_val < `OSC_SUM_LOW &&
    sif.max_val <= `OSC_MAX_HIGH && exp_r < 16'(`OSC_EXP_MAX - `OSC_EXP_STEP)
    |=> exp_r == 16'($past(exp_r) + `OSC_EXP_STEP))
    else $error("exposure did not rise on dark frame");
  a_grab_pop: assert property (grab_pop_w |=> reg_rdata_o == {1'b1, $past(grab_hold_r)} &&
    !grab_valid_r && grab_pend_r && grab_idx_r != $past(grab_idx_r))
    else $error("sampler read did not advance");
  a_grab_empty: assert property (grab_rd_w && !grab_valid_r && !grab_wr_w |=>
    !reg_rdata_o[7] && grab_idx_r == $past(grab_idx_r))
    else $error("empty sampler read misbehaved");
  a_grab_once: assert property (cap_w |=> grab_valid_r && !grab_armed_r ##1 !cap_w)
    else $error("sampler captured twice");
  a_grab_write: assert property (grab_wr_w |=> grab_idx_r == `OSC_PIX_FIRST &&
    !grab_valid_r && grab_pend_r)
    else $error("sampler write did not rearm");
  a_burst_first: assert property (burst_go_w && !sel_lvl_r |=>
    reg_rdata_o == $past(dx_acc_r) && burst_r == BS_DY)
    else $error("burst did not start with x displacement");
  a_burst_walk: assert property (s_burst_read(BS_EH) ##[1:8] s_burst_read(BS_EL) |=>
    reg_rdata_o == $past(exp_lo_snap_r) && burst_r == BS_MAX)
    else $error("burst exposure order broken");
  a_burst_hold: assert property (s_burst_read(BS_SUM) |=>
    burst_r == BS_SUM && reg_rdata_o == $past(sum_byte_w))
    else $error("burst did not hold on total");
  a_burst_exit: assert property (sel_lvl_r |=> burst_r == BS_IDLE)
    else $error("burst survived deselect");
  a_delta_clear: assert property (burst_go_w && !motion_valid_i |=> dx_acc_r == `OSC_BYTE_ZERO)
    else $error("x displacement not cleared by read");
  a_inv_rev: assert property (reg_rd_i && !burst_on_w && hit(reg_addr_i, `OSC_ADDR_INVREV)
    |=> reg_rdata_o == ~REV_CODE)
    else $error("inverted revision wrong");
  a_settings_rw: assert property (ctrl_wr_w |=> power_down_o == $past(reg_wdata_i[1]) &&
    counts_per_inch_select_o == $past(reg_wdata_i[0]))
    else $error("settings write lost");
  a_key_restart: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    key_w |=> chip_restart_o ##1 (exposure_o == `OSC_EXP_RST && ctrl_r == `OSC_CTRL_RST))
    else $error("restart key ignored");
endmodule : osc_sensor_regs

// ==== osc_far_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Pixel array and motion engine standing behind the register bank
module osc_far_model
(
  input wire logic clk_sys_i,
  output logic pix_valid_o = 1'b0,
  output logic pix_first_o = 1'b0,
  output logic [6:0] pix_data_o = 7'h00,
  output logic motion_valid_o = 1'b0,
  output logic [7:0] motion_dx_o = 8'h00,
  output logic [7:0] motion_dy_o = 8'h00,
  output logic [8:0] squal_o = 9'h000
);
  // One frame of 225 pixels, one per cycle, position 0 flagged
  task automatic frame(input logic flat, input logic [6:0] shade);
    for (int p = 0; p < 225; p++)
    begin
      @(posedge clk_sys_i);
      pix_valid_o <= 1'b1;
      pix_first_o <= (p == 0);
      pix_data_o <= flat ? shade : 7'((p * 3) + shade);
    end
    @(posedge clk_sys_i);
    pix_valid_o <= 1'b0;
    pix_first_o <= 1'b0;
    // Idle data flips so nothing can lean on a stale pixel
    pix_data_o <= ~pix_data_o;
  endtask : frame
  task automatic move(input logic [7:0] dx, input logic [7:0] dy);
    @(posedge clk_sys_i);
    motion_valid_o <= 1'b1;
    motion_dx_o <= dx;
    motion_dy_o <= dy;
    @(posedge clk_sys_i);
    motion_valid_o <= 1'b0;
    motion_dx_o <= ~dx;
    motion_dy_o <= ~dy;
  endtask : move
  task automatic set_squal(input logic [8:0] q);
    @(posedge clk_sys_i);
    squal_o <= q;
  endtask : set_squal
endmodule : osc_far_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  // Arbitrary revision code
  localparam logic [7:0] REV = 8'h3c;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic select_low_line = 1'b1;
  logic [6:0] reg_addr = 7'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic pix_valid;
  logic pix_first;
  logic [6:0] pix_data;
  logic motion_valid;
  logic [7:0] motion_dx;
  logic [7:0] motion_dy;
  logic [8:0] squal;
  logic power_down;
  logic cpi_sel;
  logic [15:0] exposure;
  logic chip_restart;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  logic sleep_on = 1'b0;
  logic [6:0] e_max = 7'h00;
  logic [6:0] e_min = 7'h00;
  logic [14:0] e_sum = 15'h0000;
  logic [15:0] e_exp = 16'h0000;
  logic [7:0] v;
  logic [6:0] zero_addr [9] = '{7'h06, 7'h07, 7'h09, 7'h0a, 7'h0b, 7'h0d, 7'h0c, 7'h3a, 7'h40};

  always #2.5 clk_sys_i = ~clk_sys_i;

  osc_sensor_regs #(.REV_CODE(REV)) i_dut (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .select_low_line_i(select_low_line),
    .reg_addr_i(reg_addr),
    .reg_rd_i(reg_rd),
    .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid),
    .pix_valid_i(pix_valid),
    .pix_first_i(pix_first),
    .pix_data_i(pix_data),
    .motion_valid_i(motion_valid),
    .motion_dx_i(motion_dx),
    .motion_dy_i(motion_dy),
    .squal_i(squal),
    .power_down_o(power_down),
    .counts_per_inch_select_o(cpi_sel),
    .exposure_o(exposure),
    .chip_restart_o(chip_restart)
  );

  osc_far_model i_far (
    .clk_sys_i(clk_sys_i),
    .pix_valid_o(pix_valid),
    .pix_first_o(pix_first),
    .pix_data_o(pix_data),
    .motion_valid_o(motion_valid),
    .motion_dx_o(motion_dx),
    .motion_dy_o(motion_dy),
    .squal_o(squal)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if ((fails == 0) && (compares > 0))
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1;
    check("rvalid", 16'(reg_rvalid), 16'h0001);
    d = reg_rdata;
  endtask : rd

  task automatic rc(input string nm, input logic [6:0] a, input logic [7:0] e);
    rd(a, v);
    check(nm, 16'(v), 16'(e));
  endtask : rc

  function automatic logic [6:0] pix(input int k, input logic flat, input logic [6:0] s);
    return flat ? s : 7'((k * 3) + s);
  endfunction : pix

  // Plays a frame and, unless sleep_on is set, updates the expected statistics and exposure
  task automatic run_frame(input logic flat, input logic [6:0] shade);
    logic [6:0] p;
    logic [6:0] mx;
    logic [6:0] mn;
    logic [14:0] sm;
    mx = 7'h00;
    mn = 7'h7f;
    sm = 15'h0000;
    for (int k = 0; k < 225; k++)
    begin
      p = pix(k, flat, shade);
      mx = (p > mx) ? p : mx;
      mn = (p < mn) ? p : mn;
      sm = sm + 15'(p);
    end
    i_far.frame(flat, shade);
    repeat (4) @(posedge clk_sys_i);
    if (!sleep_on)
    begin
      e_max = mx;
      e_min = mn;
      e_sum = sm;
      if ((mx > 7'h78) || (sm > 15'h5800))
        e_exp = (e_exp <= 16'h0010) ? 16'h0001 : e_exp - 16'h0010;
      else if (sm < 15'h1800)
        e_exp = (e_exp >= 16'hffef) ? 16'hffff : e_exp + 16'h0010;
    end
  endtask : run_frame

  task automatic stats();
    rc("brightest", 7'h08, {1'b0, e_max});
    rc("total", 7'h09, e_sum[14:7]);
    rc("darkest", 7'h0a, {1'b0, e_min});
    rc("exp_high", 7'h06, e_exp[15:8]);
    rc("exp_low", 7'h07, e_exp[7:0]);
    check("exposure", exposure, e_exp);
  endtask : stats

  task automatic burst(input logic [7:0] dx, input logic [7:0] dy, input logic [7:0] sq);
    @(posedge clk_sys_i);
    select_low_line <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rc("dx", 7'h63, dx);
    rc("dy", 7'h0c, dy);
    rc("squal", 7'h3f, sq);
    rc("b_exp_hi", 7'h00, e_exp[15:8]);
    rc("b_exp_lo", 7'h00, e_exp[7:0]);
    rc("b_max", 7'h00, {1'b0, e_max});
    repeat (3) rc("b_total", 7'h63, e_sum[14:7]);
    @(posedge clk_sys_i);
    select_low_line <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rc("after", 7'h3f, ~REV);
  endtask : burst

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    foreach (zero_addr[i])
      rc("zero", zero_addr[i], 8'h00);
    check("pins", {13'h0000, power_down, cpi_sel, chip_restart}, 16'h0000);
    rc("inv_rev", 7'h3f, ~REV);
    repeat (17) run_frame(1'b1, 7'h0a);
    stats();
    run_frame(1'b1, 7'h7f);
    stats();
    run_frame(1'b0, 7'h05);
    wr(7'h08, 8'h11);
    stats();
    i_far.move(8'he0, 8'hfd);
    i_far.move(8'h02, 8'hfe);
    i_far.set_squal(9'h12d);
    burst(8'he2, 8'hfb, 8'h96);
    i_far.move(8'h70, 8'h01);
    i_far.move(8'h18, 8'h01);
    i_far.set_squal(9'h001);
    burst(8'h7f, 8'h02, 8'h00);
    wr(7'h0d, 8'hff);
    rc("settings", 7'h0d, 8'h03);
    check("pins", {14'h0000, power_down, cpi_sel}, 16'h0003);
    wr(7'h0d, 8'h01);
    rc("settings", 7'h0d, 8'h01);
    check("pins", {14'h0000, power_down, cpi_sel}, 16'h0001);
    wr(7'h0b, 8'h77);
    for (int i = 0; i < 225; i++)
    begin
      run_frame(1'b0, 7'h05);
      rc("sample", 7'h0b, {1'b1, pix(i, 1'b0, 7'h05)});
    end
    rc("empty", 7'h0b, 8'h00);
    run_frame(1'b0, 7'h05);
    rc("wrap", 7'h0b, {1'b1, pix(0, 1'b0, 7'h05)});
    run_frame(1'b0, 7'h05);
    rc("next", 7'h0b, {1'b1, pix(1, 1'b0, 7'h05)});
    wr(7'h0b, 8'h00);
    run_frame(1'b0, 7'h05);
    rc("rearm", 7'h0b, {1'b1, pix(0, 1'b0, 7'h05)});
    wr(7'h0d, 8'h02);
    sleep_on = 1'b1;
    run_frame(1'b1, 7'h7f);
    stats();
    rc("sleep_sample", 7'h0b, 8'h00);
    check("sleep_pin", 16'(power_down), 16'h0001);
    sleep_on = 1'b0;
    wr(7'h0d, 8'h01);
    wr(7'h3a, 8'h33);
    #1;
    check("restart", 16'(chip_restart), 16'h0000);
    wr(7'h3a, 8'h5a);
    #1;
    check("restart", 16'(chip_restart), 16'h0001);
    repeat (2) @(posedge clk_sys_i);
    rc("settings", 7'h0d, 8'h00);
    check("exposure", exposure, 16'h0000);
    finish_test();
  end
endmodule : tb
